//--- design/smc_pkg.sv
package smc_pkg;

	localparam int SMC_ADDR_W     = 5;
	localparam int SMC_DATA_W     = 32;
	localparam int SMC_CFG_W      = 24;
	localparam int SMC_LIMIT_W    = 10;
	localparam int SMC_NUM_SHADOW = 13;
	localparam int SMC_DEV_ADDR_W = 6;
	localparam int SMC_FRAME_W    = 32;
	localparam int SMC_NUM_RULES  = 11;

	// Software register indices on the command port.
	localparam logic [4:0] SMC_IDX_TWO_LEVEL   = 5'h00;
	localparam logic [4:0] SMC_IDX_THREE_AB    = 5'h01;
	localparam logic [4:0] SMC_IDX_THREE_C_T8  = 5'h02;
	localparam logic [4:0] SMC_IDX_TOP_9       = 5'h03;
	localparam logic [4:0] SMC_IDX_SUPPLY0     = 5'h04;
	localparam logic [4:0] SMC_IDX_SUPPLY1     = 5'h05;
	localparam logic [4:0] SMC_IDX_CONFIG      = 5'h06;
	localparam logic [4:0] SMC_IDX_IN_EN       = 5'h07;
	localparam logic [4:0] SMC_IDX_MODE        = 5'h08;
	localparam logic [4:0] SMC_IDX_CS_SELECT   = 5'h09;
	localparam logic [4:0] SMC_IDX_WC_LOW      = 5'h0A;
	localparam logic [4:0] SMC_IDX_WC_HIGH     = 5'h0B;
	localparam logic [4:0] SMC_IDX_MATRIX      = 5'h0C;
	localparam logic [4:0] SMC_IDX_CTRL        = 5'h10;
	localparam logic [4:0] SMC_IDX_STATUS      = 5'h11;
	localparam logic [4:0] SMC_IDX_RESP        = 5'h12;

	// Device register address of each shadow word, in shadow order.
	localparam logic [5:0] SMC_DEV_ADDR [0:12] = '{
		6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
		6'h08, 6'h32, 6'h09, 6'h0A, 6'h0B, 6'h0C
	};

	localparam int SMC_LIMIT_A_LSB  = 0;
	localparam int SMC_LIMIT_B_LSB  = 10;
	localparam int SMC_POLL_EN_BIT  = 0;
	localparam int SMC_MATRIX_LSB   = 3;
	localparam logic [1:0] SMC_MATRIX_4X4 = 2'h1;
	localparam int SMC_SINK_GRP_LSB = 4;
	localparam int SMC_SRC_GRP_LSB  = 10;
	localparam int SMC_GRP_W        = 4;
	localparam logic [3:0] SMC_GRP_ALL_ONE  = 4'hF;
	localparam logic [3:0] SMC_GRP_ALL_ZERO = 4'h0;

	localparam int SMC_SINK0_LSB = 18;
	localparam int SMC_SRC0_LSB  = 6;
	localparam int SMC_SINK1_LSB = 21;
	localparam int SMC_SRC1_LSB  = 9;
	localparam int SMC_SINK2_LSB = 0;
	localparam int SMC_SRC2_LSB  = 12;
	localparam logic [2:0] SMC_WC_1MA      = 3'h1;
	localparam logic [2:0] SMC_WC_2MA      = 3'h2;
	localparam logic [2:0] SMC_WC_SINK_MIN = 3'h2;
	localparam logic [2:0] SMC_WC_SINK_2MA = 3'h3;

	localparam int SMC_CTRL_START_BIT = 0;
	localparam int SMC_CTRL_TW_BIT    = 1;
	localparam int SMC_CTRL_FORCE_BIT = 2;
	localparam int SMC_CTRL_CLR_BIT   = 3;

	localparam int SMC_STAT_BUSY_BIT   = 0;
	localparam int SMC_STAT_VIOL_BIT   = 1;
	localparam int SMC_STAT_REFUSE_BIT = 2;
	localparam int SMC_STAT_DONE_BIT   = 3;
	localparam int SMC_STAT_VEC_LSB    = 4;

	localparam int SMC_FRAME_WR_BIT   = 31;
	localparam int SMC_FRAME_ADDR_LSB = 25;
	localparam int SMC_FRAME_DATA_LSB = 1;

	localparam logic [23:0] SMC_SHADOW_RST = 24'h000000;
	localparam logic [1:0]  SMC_SCLK_HALF  = 2'h1;
	localparam logic [4:0]  SMC_LAST_BIT   = 5'h1F;
	localparam logic [3:0]  SMC_LAST_IDX   = 4'hC;

endpackage

//--- design/smc_link_if.sv
interface smc_link_if;
	logic        start;
	logic [31:0] frame;
	logic        busy;
	logic        done;
	logic [31:0] rx_word;

	modport master (output start, output frame,
		input busy, input done, input rx_word);
	modport shifter (input start, input frame,
		output busy, output done, output rx_word);
endinterface

//--- design/smc_spi_shifter.sv
module smc_spi_shifter
	import smc_pkg::*;
(
	input  wire logic    mclk,
	input  wire logic    sys_rst,
	smc_link_if.shifter  link,
	input  wire logic    spi_miso,
	output logic         spi_sclk,
	output logic         spi_cs_n,
	output logic         spi_mosi
);

	typedef enum logic {SH_IDLE, SH_RUN} smc_sh_type;

	smc_sh_type  state_q;
	logic [1:0]  div_q;
	logic [4:0]  bit_q;
	logic [31:0] sh_q;
	logic [31:0] rx_q;
	logic        done_q;
	logic        tick;

	// One-cycle enable at each half period of the serial clock.
	assign tick = (state_q == SH_RUN) && (div_q == SMC_SCLK_HALF);

	assign link.busy    = (state_q == SH_RUN);
	assign link.done    = done_q;
	assign link.rx_word = rx_q;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			div_q <= 2'h0;
		end else if (state_q != SH_RUN || tick) begin
			div_q <= 2'h0;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q  <= SH_IDLE;
			bit_q    <= 5'h00;
			sh_q     <= 32'h00000000;
			spi_sclk <= 1'b0;
			spi_cs_n <= 1'b1;
			spi_mosi <= 1'b0;
			done_q   <= 1'b0;
		end else begin
			done_q <= 1'b0;
			unique case (state_q)
				SH_IDLE: begin
					if (link.start) begin
						state_q  <= SH_RUN;
						sh_q     <= link.frame << 1;
						spi_mosi <= link.frame[31];
						spi_cs_n <= 1'b0;
						bit_q    <= 5'h00;
					end
				end
				SH_RUN: begin
					if (tick && !spi_sclk) begin
						spi_sclk <= 1'b1;
					end else if (tick) begin
						spi_sclk <= 1'b0;
						if (bit_q == SMC_LAST_BIT) begin
							state_q  <= SH_IDLE;
							spi_cs_n <= 1'b1;
							spi_mosi <= 1'b0;
							done_q   <= 1'b1;
						end else begin
							spi_mosi <= sh_q[31];
							sh_q     <= sh_q << 1;
							bit_q    <= bit_q + 5'h01;
						end
					end
				end
			endcase
		end
	end

	// Device answer is sampled on each rising serial clock edge.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_q <= 32'h00000000;
		end else if (tick && !spi_sclk) begin
			rx_q <= {rx_q[30:0], spi_miso};
		end
	end

endmodule

//--- design/smc_config_host.sv
// Notes on behaviour
// - Two-level limit B must be at least limit A for inputs 12 to 17.
// - For inputs 18 to 22 the three-level limits must rise: C >= B >= A.
// - For input 23 the chain 9 >= 8 >= C >= B >= A must hold.
// - In both supply sets limit B must be at least limit A.
// - Selecting the 4x4 matrix needs the polling enable set.
// - In 4x4 matrix, inputs 4 to 7 and 10 to 13 must be enabled.
// - In 4x4 matrix, those inputs must all be in comparator mode.
// - In 4x4 matrix, inputs 4 to 7 sink and inputs 10 to 13 source.
// - In 4x4 matrix, each sink wetting code exceeds its source code.
// - In 4x4 matrix with warnings expected, every source code is 1 mA or 2 mA.
// - In 4x4 matrix with warnings expected, source 001 needs sink >= 010, 010 needs 011.
module smc_config_host
	import smc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic [4:0]  addr,
	input  wire logic [31:0] wr_data,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic      [31:0] rd_data,
	output logic             violation,
	output logic             busy,
	input  wire logic        spi_miso,
	output logic             spi_sclk,
	output logic             spi_cs_n,
	output logic             spi_mosi
);

	typedef enum logic [1:0] {PS_IDLE, PS_SEND, PS_WAIT} smc_push_type;

	function automatic logic limit_ge(input logic [9:0] hi,
		input logic [9:0] lo);
		return hi >= lo;
	endfunction

	function automatic logic [9:0] field_a(input logic [23:0] w);
		return w[SMC_LIMIT_A_LSB +: SMC_LIMIT_W];
	endfunction

	function automatic logic [9:0] field_b(input logic [23:0] w);
		return w[SMC_LIMIT_B_LSB +: SMC_LIMIT_W];
	endfunction

	function automatic logic src_code_ok(input logic [2:0] src);
		return (src == SMC_WC_1MA) || (src == SMC_WC_2MA);
	endfunction

	function automatic logic pair_tw_ok(input logic [2:0] sink,
		input logic [2:0] src);
		logic ok;
		ok = 1'b1;
		if (src == SMC_WC_1MA) begin
			ok = sink >= SMC_WC_SINK_MIN;
		end else if (src == SMC_WC_2MA) begin
			ok = sink == SMC_WC_SINK_2MA;
		end
		return ok;
	endfunction

	// True when a four-input group of a word differs from the value needed.
	function automatic logic group_off(input logic [23:0] w,
		input int lsb, input logic [3:0] need);
		return w[lsb +: SMC_GRP_W] != need;
	endfunction

	// Write frame: command bit, device address, data, then odd parity.
	function automatic logic [31:0] write_frame(input logic [5:0] dev,
		input logic [23:0] data);
		logic [31:0] f;
		f = 32'h00000000;
		f[SMC_FRAME_WR_BIT] = 1'b1;
		f[SMC_FRAME_ADDR_LSB +: SMC_DEV_ADDR_W] = dev;
		f[SMC_FRAME_DATA_LSB +: SMC_CFG_W] = data;
		f[0] = ~^f[31:1];
		return f;
	endfunction

	logic [23:0]  shadow_q [0:12];
	logic         tw_expect_q;
	logic         force_q;
	logic         refused_q;
	logic         push_done_q;
	logic [10:0]  viol_vec_q;
	logic [10:0]  viol_vec_d;
	logic         viol_any_d;
	smc_push_type push_q;
	logic [3:0]   idx_q;
	logic         start_q;
	logic [31:0]  frame_q;
	logic [31:0]  resp_q;
	logic [31:0]  rd_word_d;
	logic         wr_shadow;
	logic         wr_ctrl;
	logic         start_req;
	logic         push_ok;
	logic         matrix_4x4;
	logic [23:0]  cfg_w;
	logic [23:0]  in_en_w;
	logic [23:0]  mode_w;
	logic [23:0]  cs_w;
	logic [23:0]  wcl;
	logic [23:0]  wch;
	logic [2:0]   sink0;
	logic [2:0]   sink1;
	logic [2:0]   sink2;
	logic [2:0]   src0;
	logic [2:0]   src1;
	logic [2:0]   src2;

	smc_link_if link ();

	smc_spi_shifter u_shifter (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.link     (link.shifter),
		.spi_miso (spi_miso),
		.spi_sclk (spi_sclk),
		.spi_cs_n (spi_cs_n),
		.spi_mosi (spi_mosi)
	);

	assign link.start = start_q;
	assign link.frame = frame_q;

	// Shadow words are frozen while a push runs, so a frame never mixes
	// old and new settings.
	assign wr_shadow = wr_stb && (addr <= SMC_IDX_MATRIX)
		&& (push_q == PS_IDLE);
	assign wr_ctrl   = wr_stb && (addr == SMC_IDX_CTRL);
	assign start_req = wr_ctrl && wr_data[SMC_CTRL_START_BIT]
		&& (push_q == PS_IDLE);
	assign push_ok   = !viol_any_d || wr_data[SMC_CTRL_FORCE_BIT];

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < SMC_NUM_SHADOW; i++) begin
				shadow_q[i] <= SMC_SHADOW_RST;
			end
		end else if (wr_shadow) begin
			shadow_q[addr[3:0]] <= wr_data[SMC_CFG_W-1:0];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tw_expect_q <= 1'b0;
			force_q     <= 1'b0;
		end else if (wr_ctrl) begin
			tw_expect_q <= wr_data[SMC_CTRL_TW_BIT];
			force_q     <= wr_data[SMC_CTRL_FORCE_BIT];
		end
	end

	assign cfg_w   = shadow_q[SMC_IDX_CONFIG[3:0]];
	assign in_en_w = shadow_q[SMC_IDX_IN_EN[3:0]];
	assign mode_w  = shadow_q[SMC_IDX_MODE[3:0]];
	assign cs_w    = shadow_q[SMC_IDX_CS_SELECT[3:0]];
	assign wcl     = shadow_q[SMC_IDX_WC_LOW[3:0]];
	assign wch     = shadow_q[SMC_IDX_WC_HIGH[3:0]];
	assign sink0   = wcl[SMC_SINK0_LSB +: 3];
	assign sink1   = wcl[SMC_SINK1_LSB +: 3];
	assign sink2   = wch[SMC_SINK2_LSB +: 3];
	assign src0    = wcl[SMC_SRC0_LSB +: 3];
	assign src1    = wcl[SMC_SRC1_LSB +: 3];
	assign src2    = wcl[SMC_SRC2_LSB +: 3];
	assign matrix_4x4 = shadow_q[SMC_IDX_MATRIX[3:0]]
		[SMC_MATRIX_LSB +: 2] == SMC_MATRIX_4X4;

	// Each vector bit is one broken constraint; bit n stands for rule n+1.
	always_comb begin
		logic [23:0] two_w;
		logic [23:0] tab_w;
		logic [23:0] tc8_w;
		logic [23:0] t9_w;
		logic [23:0] s0_w;
		logic [23:0] s1_w;
		two_w = shadow_q[SMC_IDX_TWO_LEVEL[3:0]];
		tab_w = shadow_q[SMC_IDX_THREE_AB[3:0]];
		tc8_w = shadow_q[SMC_IDX_THREE_C_T8[3:0]];
		t9_w  = shadow_q[SMC_IDX_TOP_9[3:0]];
		s0_w  = shadow_q[SMC_IDX_SUPPLY0[3:0]];
		s1_w  = shadow_q[SMC_IDX_SUPPLY1[3:0]];
		viol_vec_d = 11'h000;
		viol_vec_d[0] = !limit_ge(field_b(two_w), field_a(two_w));
		viol_vec_d[1] = !limit_ge(field_a(tc8_w), field_b(tab_w))
			|| !limit_ge(field_b(tab_w), field_a(tab_w));
		viol_vec_d[2] = !limit_ge(field_a(t9_w), field_b(tc8_w))
			|| !limit_ge(field_b(tc8_w), field_a(tc8_w))
			|| viol_vec_d[1];
		viol_vec_d[3] = !limit_ge(field_b(s0_w), field_a(s0_w))
			|| !limit_ge(field_b(s1_w), field_a(s1_w));
		if (matrix_4x4) begin
			viol_vec_d[4] = !cfg_w[SMC_POLL_EN_BIT];
			viol_vec_d[5] =
				group_off(in_en_w, SMC_SINK_GRP_LSB, SMC_GRP_ALL_ONE)
				|| group_off(in_en_w, SMC_SRC_GRP_LSB,
				SMC_GRP_ALL_ONE);
			viol_vec_d[6] =
				group_off(mode_w, SMC_SINK_GRP_LSB, SMC_GRP_ALL_ZERO)
				|| group_off(mode_w, SMC_SRC_GRP_LSB,
				SMC_GRP_ALL_ZERO);
			viol_vec_d[7] =
				group_off(cs_w, SMC_SINK_GRP_LSB, SMC_GRP_ALL_ONE)
				|| group_off(cs_w, SMC_SRC_GRP_LSB,
				SMC_GRP_ALL_ZERO);
			viol_vec_d[8] = !(sink0 > src0) || !(sink1 > src1)
				|| !(sink2 > src2);
			if (tw_expect_q) begin
				viol_vec_d[9] = !src_code_ok(src0) || !src_code_ok(src1)
					|| !src_code_ok(src2);
				viol_vec_d[10] = !pair_tw_ok(sink0, src0)
					|| !pair_tw_ok(sink1, src1)
					|| !pair_tw_ok(sink2, src2);
			end
		end
	end

	assign viol_any_d = |viol_vec_d;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			viol_vec_q <= 11'h000;
			violation  <= 1'b0;
		end else begin
			viol_vec_q <= viol_vec_d;
			violation  <= viol_any_d;
		end
	end

	// A refused start sets the flag; the set wins over a clear request.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			refused_q <= 1'b0;
		end else if (start_req && !push_ok) begin
			refused_q <= 1'b1;
		end else if (wr_ctrl && wr_data[SMC_CTRL_CLR_BIT]) begin
			refused_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			push_done_q <= 1'b0;
		end else if (push_q == PS_WAIT && link.done
			&& idx_q == SMC_LAST_IDX) begin
			push_done_q <= 1'b1;
		end else if (wr_ctrl && wr_data[SMC_CTRL_CLR_BIT]) begin
			push_done_q <= 1'b0;
		end
	end

	// Push engine: one write frame per shadow word, in index order.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			push_q  <= PS_IDLE;
			idx_q   <= 4'h0;
			start_q <= 1'b0;
			frame_q <= 32'h00000000;
			busy    <= 1'b0;
		end else begin
			start_q <= 1'b0;
			unique case (push_q)
				PS_IDLE: begin
					if (start_req && push_ok) begin
						push_q <= PS_SEND;
						idx_q  <= 4'h0;
						busy   <= 1'b1;
					end
				end
				PS_SEND: begin
					// Wait out a frame that the shifter is still closing.
					if (!link.busy) begin
						frame_q <= write_frame(SMC_DEV_ADDR[idx_q],
							shadow_q[idx_q]);
						start_q <= 1'b1;
						push_q  <= PS_WAIT;
					end
				end
				PS_WAIT: begin
					if (link.done) begin
						if (idx_q == SMC_LAST_IDX) begin
							push_q <= PS_IDLE;
							busy   <= 1'b0;
						end else begin
							idx_q  <= idx_q + 4'h1;
							push_q <= PS_SEND;
						end
					end
				end
				default: begin
					push_q <= PS_IDLE;
					busy   <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			resp_q <= 32'h00000000;
		end else if (link.done) begin
			resp_q <= link.rx_word;
		end
	end

	// Read decode; unmapped indices read as zero.
	always_comb begin
		rd_word_d = 32'h00000000;
		if (addr <= SMC_IDX_MATRIX) begin
			rd_word_d[SMC_CFG_W-1:0] = shadow_q[addr[3:0]];
		end else begin
			unique case (addr)
				SMC_IDX_CTRL: begin
					rd_word_d[SMC_CTRL_TW_BIT]    = tw_expect_q;
					rd_word_d[SMC_CTRL_FORCE_BIT] = force_q;
				end
				SMC_IDX_STATUS: begin
					rd_word_d[SMC_STAT_BUSY_BIT]   = busy;
					rd_word_d[SMC_STAT_VIOL_BIT]   = violation;
					rd_word_d[SMC_STAT_REFUSE_BIT] = refused_q;
					rd_word_d[SMC_STAT_DONE_BIT]   = push_done_q;
					rd_word_d[SMC_STAT_VEC_LSB +: SMC_NUM_RULES] =
						viol_vec_q;
				end
				SMC_IDX_RESP: begin
					rd_word_d = resp_q;
				end
				default: begin
					rd_word_d = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data <= 32'h00000000;
		end else if (rd_stb) begin
			rd_data <= rd_word_d;
		end else begin
			rd_data <= 32'h00000000;
		end
	end

endmodule

//--- tb/smc_config_host_properties.sv
module smc_config_host_checker
	import smc_pkg::*;
(
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic [4:0]  addr,
	input wire logic [31:0] wr_data,
	input wire logic        wr_stb,
	input wire logic        rd_stb,
	input wire logic [31:0] rd_data,
	input wire logic        violation,
	input wire logic        busy,
	input wire logic        spi_miso,
	input wire logic        spi_sclk,
	input wire logic        spi_cs_n,
	input wire logic        spi_mosi
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] mx_q;
	logic       tw_q;
	logic [4:0] wa;
	logic       m4;
	logic       lt;
	logic [7:0] grp;
	logic [2:0] src;
	logic [2:0] snk;
	// Index of a write the block accepts; idle or refused cycles read 1F.
	assign wa = (wr_stb && !busy) ? addr : 5'h1F;
	assign m4 = (mx_q == SMC_MATRIX_4X4);
	assign lt = (wr_data[19:10] < wr_data[9:0]);
	assign grp = {wr_data[13:10], wr_data[7:4]};
	assign src = wr_data[8:6];
	assign snk = wr_data[20:18];
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			mx_q <= 2'h0;
			tw_q <= 1'b0;
		end else begin
			if (wa == SMC_IDX_MATRIX)
				mx_q <= wr_data[4:3];
			if (wr_stb && addr == SMC_IDX_CTRL)
				tw_q <= wr_data[SMC_CTRL_TW_BIT];
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	property p_two; wa == SMC_IDX_TWO_LEVEL && lt |-> ##[1:2] violation;
	endproperty
	a_two: assert property (p_two) else $error("two-level order");
	property p_three; wa == SMC_IDX_THREE_AB && lt |-> ##[1:2] violation;
	endproperty
	a_three: assert property (p_three) else $error("three order");
	property p_top; wa == SMC_IDX_THREE_C_T8 && lt |-> ##[1:2] violation;
	endproperty
	a_top: assert property (p_top) else $error("top chain");
	property p_sup;
		(wa == SMC_IDX_SUPPLY0 || wa == SMC_IDX_SUPPLY1) && lt
		|-> ##[1:2] violation;
	endproperty
	a_sup: assert property (p_sup) else $error("supply order");
	property p_poll; m4 && wa == SMC_IDX_CONFIG && !wr_data[0]
		|=> ##[0:1] violation;
	endproperty
	a_poll: assert property (p_poll) else $error("poll enable");
	property p_en; m4 && wa == SMC_IDX_IN_EN && grp != 8'hFF
		|-> ##[1:2] violation;
	endproperty
	a_en: assert property (p_en) else $error("input enable");
	property p_mode; m4 && wa == SMC_IDX_MODE && grp != 8'h00
		|-> ##[1:2] violation;
	endproperty
	a_mode: assert property (p_mode) else $error("input mode");
	property p_dir; m4 && wa == SMC_IDX_CS_SELECT && grp != 8'h0F
		|-> ##[1:2] violation;
	endproperty
	a_dir: assert property (p_dir) else $error("direction");
	property p_sink; m4 && wa == SMC_IDX_WC_LOW && snk <= src
		|-> ##[1:2] violation;
	endproperty
	a_sink: assert property (p_sink) else $error("sink order");
	property p_src; m4 && tw_q && wa == SMC_IDX_WC_LOW
		&& !(src inside {3'h1, 3'h2}) |-> ##[1:2] violation;
	endproperty
	a_src: assert property (p_src) else $error("source level");
	property p_pair; m4 && tw_q && wa == SMC_IDX_WC_LOW
		&& src == 3'h2 && snk != 3'h3 |-> ##[1:2] violation;
	endproperty
	a_pair: assert property (p_pair) else $error("pair level");
	property p_cause; $rose(violation) |-> $past(wr_stb, 2) || $past(wr_stb);
	endproperty
	a_cause: assert property (p_cause) else $error("flag cause");
	property p_rd; !$past(rd_stb) |-> rd_data == 32'h00000000;
	endproperty
	a_rd: assert property (p_rd) else $error("read data idle");
	property p_pins; spi_cs_n |-> !spi_sclk && !spi_mosi;
	endproperty
	a_pins: assert property (p_pins) else $error("idle link pins");
	c_push: cover property ($rose(busy));
	c_frame: cover property ($fell(spi_cs_n));
	c_flag: cover property ($rose(violation));
endmodule

bind smc_config_host smc_config_host_checker u_chk (
	.mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
	.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
	.violation(violation), .busy(busy), .spi_miso(spi_miso),
	.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi)
);

//--- tb/smc_dev_model.sv
module smc_dev_model #(
	parameter logic [31:0] REPLY = 32'h0
) (
	input  wire logic   spi_sclk,
	input  wire logic   spi_cs_n,
	input  wire logic   spi_mosi,
	output logic        spi_miso,
	output logic [31:0] fr_word,
	output int          fr_bits,
	output logic        fr_tgl
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] sh;
	int          n;
	initial begin
		spi_miso = 1'b0;
		sh = 32'h0;
		n = 0;
		fr_word = 32'h0;
		fr_bits = 0;
		fr_tgl = 1'b0;
	end
	// The first reply bit is ready as soon as the frame opens.
	always @(negedge spi_cs_n) begin
		n = 0;
		spi_miso = REPLY[31];
	end
	always @(posedge spi_sclk) begin
		if (!spi_cs_n) begin
			sh = {sh[30:0], spi_mosi};
			n = n + 1;
		end
	end
	always @(negedge spi_sclk) begin
		if (!spi_cs_n && n < 32)
			spi_miso = REPLY[31 - n];
	end
	// Outside a frame the line shows the inverse of its last bit.
	always @(posedge spi_cs_n) begin
		if (n > 0) begin
			fr_word = sh;
			fr_bits = n;
			fr_tgl = ~fr_tgl;
			spi_miso = ~spi_miso;
			n = 0;
		end
	end
endmodule

//--- tb/smc_config_host_tb_top.sv
module smc_config_host_tb_top
	import smc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] REPLY_WORD = 32'hA5C30F96;
	localparam logic [4:0] FI [0:11] = '{5'h00, 5'h01, 5'h02, 5'h04,
		5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0A, 5'h0A};
	localparam logic [23:0] FV [0:11] = '{
		24'h001005, 24'h001005, 24'h001005,
		24'h001005, 24'h001005, 24'h000000,
		24'h003CE0, 24'h000400, 24'h0004F0,
		24'h641240, 24'h7012C0, 24'h701280
	};
	localparam int FN [0:11] = '{1, 2, 3, 4, 4, 5, 6, 7, 8, 9, 10, 11};
	logic        mclk;
	logic        sys_rst;
	logic [4:0]  addr;
	logic [31:0] wr_data;
	logic        wr_stb;
	logic        rd_stb;
	logic [31:0] rd_data;
	logic        violation;
	logic        busy;
	logic        spi_miso;
	logic        spi_sclk;
	logic        spi_cs_n;
	logic        spi_mosi;
	logic [31:0] fr_word;
	int          fr_bits;
	logic        fr_tgl;
	logic        rd_p = 1'b0;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	logic [31:0] e_q [$];
	logic [31:0] m_q [$];
	logic [31:0] f_q [$];
	logic [23:0] good [0:12] = '{24'h0, 24'h0, 24'h0, 24'h0, 24'h0,
		24'h0, 24'h1, 24'h003CF0, 24'h0, 24'h0000F0, 24'h6C1240,
		24'h000003, 24'h000008};
	smc_config_host u_smc_config_host (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.addr     (addr),
		.wr_data  (wr_data),
		.wr_stb   (wr_stb),
		.rd_stb   (rd_stb),
		.rd_data  (rd_data),
		.violation(violation),
		.busy     (busy),
		.spi_miso (spi_miso),
		.spi_sclk (spi_sclk),
		.spi_cs_n (spi_cs_n),
		.spi_mosi (spi_mosi)
	);
	smc_dev_model #(.REPLY(REPLY_WORD)) u_smc_dev_model (
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi),
		.spi_miso(spi_miso),
		.fr_word (fr_word),
		.fr_bits (fr_bits),
		.fr_tgl  (fr_tgl)
	);
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic chk(string nm, logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic complete_run;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic wr(logic [4:0] a, logic [23:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= {8'hA5, d};
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(logic [4:0] a, logic [31:0] e, m);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		e_q.push_back(e & m);
		m_q.push_back(m);
		@(posedge mclk);
		rd_stb <= 1'b0;
	endtask
	task automatic push(logic [23:0] c);
		logic [31:0] f;
		int          k;
		for (int i = 0; i < 13; i++) begin
			f = {1'b1, SMC_DEV_ADDR[i], good[i], 1'b0};
			f[0] = ~^f[31:1];
			f_q.push_back(f);
		end
		wr(SMC_IDX_CTRL, c);
		wr(SMC_IDX_IN_EN, 24'hFFFFFF);
		k = 0;
		while (busy !== 1'b0 && k < 4000) begin
			@(posedge mclk);
			k++;
		end
		if (k == 4000) begin
			n_mismatch++;
			complete_run();
		end
		rd(SMC_IDX_IN_EN, {8'h00, good[7]}, '1);
		rd(SMC_IDX_STATUS, 32'h8, 32'hD);
		rd(SMC_IDX_RESP, REPLY_WORD, '1);
	endtask
	always @(posedge mclk) begin
		if (rd_p)
			chk("rd_data", rd_data & m_q.pop_front(), e_q.pop_front());
		rd_p <= rd_stb;
	end
	always @(fr_tgl) begin
		if (sys_rst === 1'b0) begin
			chk("frame", fr_word, f_q.pop_front());
			chk("frame bits", 32'(fr_bits), 32'd32);
		end
	end
	initial begin
		logic [9:0]  a;
		logic [9:0]  b;
		logic [31:0] m;
		sys_rst = 1'b1;
		addr = 5'h00;
		wr_data = 32'h0;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		void'($urandom(97));
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		chk("idle", {28'h0, spi_cs_n, spi_sclk, violation, busy}, 32'h8);
		rd(SMC_IDX_STATUS, 32'h0, '1);
		wr(5'h0D, 24'h123456);
		rd(5'h0D, 32'h0, '1);
		for (int i = 0; i < 13; i++)
			wr(5'(i), good[i]);
		wr(SMC_IDX_CTRL, 24'h2);
		rd(SMC_IDX_STATUS, 32'h0, 32'h2);
		for (int i = 0; i < 12; i++) begin
			m = 32'h2 | (32'h1 << (FN[i] + 3));
			wr(FI[i], FV[i]);
			rd(FI[i], {8'h00, FV[i]}, '1);
			rd(SMC_IDX_STATUS, m, m);
			wr(FI[i], good[FI[i]]);
			rd(SMC_IDX_STATUS, 32'h0, 32'h2);
		end
		wr(SMC_IDX_CTRL, 24'h0);
		wr(SMC_IDX_WC_LOW, 24'h7012C0);
		rd(SMC_IDX_STATUS, 32'h0, 32'h2);
		wr(SMC_IDX_WC_LOW, good[10]);
		wr(SMC_IDX_MATRIX, 24'h0);
		wr(SMC_IDX_CONFIG, 24'h0);
		rd(SMC_IDX_STATUS, 32'h0, 32'h2);
		wr(SMC_IDX_CONFIG, good[6]);
		wr(SMC_IDX_MATRIX, good[12]);
		for (int i = 0; i < 8; i++) begin
			a = 10'($urandom_range(1023, 0));
			b = 10'($urandom_range(1023, a));
			good[0] = {4'h0, b, a};
			good[5] = {4'h0, b, a};
			wr(SMC_IDX_TWO_LEVEL, good[0]);
			wr(SMC_IDX_SUPPLY1, good[5]);
			rd(SMC_IDX_STATUS, 32'h0, 32'h2);
		end
		push(24'h3);
		good[6] = 24'h0;
		wr(SMC_IDX_CONFIG, good[6]);
		wr(SMC_IDX_CTRL, 24'h3);
		rd(SMC_IDX_STATUS, 32'h4, 32'h5);
		wr(SMC_IDX_CTRL, 24'h8);
		rd(SMC_IDX_STATUS, 32'h0, 32'hC);
		push(24'h7);
		repeat (3) @(posedge mclk);
		chk("left", 32'(e_q.size() + f_q.size()), 32'h0);
		complete_run();
	end
endmodule
